//--- rtl/ogt_trim_bank.v
// Offset and fine gain trim bank, Avalon-MM slave with waitrequest.
// Holds eight trim words and turns them into per-core corrections.
// Assumes synchronous inputs; fuse data is stable after reset release.
// Assumes the cores report their sampled pair on the selector inputs.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`include "ogt_map.vh"

// What this block does
// - Offset at 0x336 drives core 2 on second pair
// - Core 3 offsets: 0x338 third, 0x33A fourth pair
// - Offsets 0x33C core 4, 0x33E core 5 always
// - Gains 0x360 core 0, 0x361 core 1
// - Gain 0x362 drives core 2 on first pair
// - Fields load defaults from fuse storage
// - Registers reset to zero, all fields read/write
// - Offset correction is an unsigned value
module ogt_trim_bank (
   input  wire        clk_in,             // 250 MHz clock
   input  wire        nrst_in,            // Async reset, active low
   // Avalon-MM slave
   input  wire [13:0] avs_address_in,     // Byte address
   input  wire        avs_read_in,        // Read request
   input  wire        avs_write_in,       // Write request
   input  wire [31:0] avs_writedata_in,   // Write data
   input  wire [3:0]  avs_byteenable_in,  // Byte lanes
   output reg  [31:0] avs_readdata_out,   // Read data
   output reg         avs_waitrequest_out, // Stall
   // Fuse defaults
   input  wire [15:0] fuse_ofs_c2b_in,    // Factory offset core 2 pair B
   input  wire [15:0] fuse_ofs_c3c_in,    // Factory offset core 3 pair C
   input  wire [15:0] fuse_ofs_c3d_in,    // Factory offset core 3 pair D
   input  wire [15:0] fuse_ofs_c4_in,     // Factory offset core 4
   input  wire [15:0] fuse_ofs_c5_in,     // Factory offset core 5
   input  wire [7:0]  fuse_gain_c0_in,    // Factory gain core 0
   input  wire [7:0]  fuse_gain_c1_in,    // Factory gain core 1
   input  wire [7:0]  fuse_gain_c2a_in,   // Factory gain core 2 pair A
   // Input pair selectors
   input  wire [1:0]  core2_sel_in,       // Pair sampled by core 2
   input  wire [1:0]  core3_sel_in,       // Pair sampled by core 3
   // Corrections to the converter datapath
   output reg  [11:0] core2_ofs_out,      // Core 2 offset (pair B)
   output reg         core2_ofs_vld_out,  // Core 2 offset applies now
   output reg  [11:0] core3_ofs_out,      // Core 3 offset (pair C or D)
   output reg         core3_ofs_vld_out,  // Core 3 offset applies now
   output reg  [11:0] core4_ofs_out,      // Core 4 offset
   output reg  [11:0] core5_ofs_out,      // Core 5 offset
   output reg  [4:0]  core0_gain_out,     // Core 0 fine gain
   output reg  [4:0]  core1_gain_out,     // Core 1 fine gain
   output reg  [4:0]  core2_gain_out,     // Core 2 fine gain (pair A)
   output reg         core2_gain_vld_out, // Core 2 gain applies now
   output reg         fuse_done_out       // Fuse defaults loaded
);

   localparam NREG = 8;               // Registers in the bank

   // The bus answers every request the same way: the request is seen in
   // idle, waitrequest drops for exactly one cycle, then one quiet cycle
   // passes before the next request is looked at. Reads and writes to
   // holes in the map are answered like any other, with zero data.
   // Bus FSM states
   localparam ST_IDLE = 2'h0;         // Waiting for a request
   localparam ST_ANS  = 2'h1;         // Answer, waitrequest low
   localparam ST_DONE = 2'h2;         // Gap while master releases

   // Fuse load sequencer
   reg  [3:0]  fuse_cnt_q;             // Wait counter after reset
   reg         fuse_load_q;            // One-cycle load pulse
   reg         fuse_done_q;            // Load finished

   // Bus handling
   reg  [1:0]  st_q;                   // Bus state
   reg  [1:0]  st_d;                   // Next bus state
   wire [11:0] idx;                    // Register index from address
   wire        addr_ok;                // Word aligned access
   reg  [NREG-1:0] hit;                // One-hot register decode
   wire [NREG-1:0] wr_sel;             // Per-register write strobes
   reg  [31:0] rmux;                   // Read mux

   // Each word lives in its own small register module
   // Register contents
   wire [15:0] ofs_c2b;                // Offset core 2 pair B
   wire [15:0] ofs_c3c;                // Offset core 3 pair C
   wire [15:0] ofs_c3d;                // Offset core 3 pair D
   wire [15:0] ofs_c4;                 // Offset core 4
   wire [15:0] ofs_c5;                 // Offset core 5
   wire [7:0]  gain_c0;                // Gain core 0
   wire [7:0]  gain_c1;                // Gain core 1
   wire [7:0]  gain_c2a;               // Gain core 2 pair A
   wire [15:0] wd16;                   // Byte-masked 16-bit write data
   wire [7:0]  wd8;                    // Byte-masked 8-bit write data

   // Fuse defaults are taken a few cycles after reset release, not under
   // reset, so the async reset only ever loads constants. The wait gives
   // the fuse array time to settle; a write landing in the load cycle
   // still wins, since a deliberate software value outranks the default.
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         fuse_cnt_q  <= 4'h0;
         fuse_load_q <= 1'b0;
         fuse_done_q <= 1'b0;
      end else begin
         // Load pulse lasts a single cycle
         fuse_load_q <= 1'b0;
         if (!fuse_done_q) begin
            // Fire once when the settling wait has run out
            if (fuse_cnt_q == `OGT_FUSE_WAIT) begin
               fuse_load_q <= 1'b1;
               fuse_done_q <= 1'b1;
            end else begin
               // Still settling; the done flag freezes the counter
               fuse_cnt_q <= fuse_cnt_q + 4'h1;
            end
         end
      end
   end

   // Address decode: index is byte address over four
   // Low two address bits must be zero, else the access is a hole
   assign idx     = avs_address_in[13:`OGT_ADDR_SHIFT];
   assign addr_ok = (avs_address_in[1:0] == 2'h0);

   // One-hot decode of the eight trim registers
   // A miss leaves every strobe low, so holes take no write
   always @* begin
      hit = {NREG{1'b0}};
      if (addr_ok) begin
         case (idx)
            `OGT_IDX_OFS_C2B:  hit[0] = 1'b1;
            `OGT_IDX_OFS_C3C:  hit[1] = 1'b1;
            `OGT_IDX_OFS_C3D:  hit[2] = 1'b1;
            `OGT_IDX_OFS_C4:   hit[3] = 1'b1;
            `OGT_IDX_OFS_C5:   hit[4] = 1'b1;
            `OGT_IDX_GAIN_C0:  hit[5] = 1'b1;
            `OGT_IDX_GAIN_C1:  hit[6] = 1'b1;
            `OGT_IDX_GAIN_C2A: hit[7] = 1'b1;
            default:           hit = {NREG{1'b0}};
         endcase
      end
   end

   // Write takes effect only in the answer cycle, exactly once per request.
   // Upper bits are stored as written; software keeps them zero.
   assign wr_sel = (st_q == ST_ANS && avs_write_in) ? hit : {NREG{1'b0}};

   // Byte lanes merge new data with the held value
   // Lanes 2 and 3 have no storage behind them and are ignored
   assign wd16 = {avs_byteenable_in[1] ? avs_writedata_in[15:8] : 8'h00,
                  avs_byteenable_in[0] ? avs_writedata_in[7:0]  : 8'h00};
   assign wd8  = avs_byteenable_in[0] ? avs_writedata_in[7:0] : 8'h00;

   // Offset registers (16 bit)
   // Core 2 offset, used while it samples the second pair
   ogt_trim_reg #(.W(`OGT_OFS_REG_W)) u_ofs_c2b (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .load_in   (fuse_load_q),
      .fuse_in   (fuse_ofs_c2b_in),
      .wr_in     (wr_sel[0]),
      .wdata_in  (lane16(ofs_c2b)),
      .value_out (ofs_c2b)
   );
   // Core 3 offset for its third pair
   ogt_trim_reg #(.W(`OGT_OFS_REG_W)) u_ofs_c3c (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .load_in   (fuse_load_q),
      .fuse_in   (fuse_ofs_c3c_in),
      .wr_in     (wr_sel[1]),
      .wdata_in  (lane16(ofs_c3c)),
      .value_out (ofs_c3c)
   );
   // Core 3 offset for its fourth pair
   ogt_trim_reg #(.W(`OGT_OFS_REG_W)) u_ofs_c3d (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .load_in   (fuse_load_q),
      .fuse_in   (fuse_ofs_c3d_in),
      .wr_in     (wr_sel[2]),
      .wdata_in  (lane16(ofs_c3d)),
      .value_out (ofs_c3d)
   );
   // Core 4 offset, independent of the pair
   ogt_trim_reg #(.W(`OGT_OFS_REG_W)) u_ofs_c4 (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .load_in   (fuse_load_q),
      .fuse_in   (fuse_ofs_c4_in),
      .wr_in     (wr_sel[3]),
      .wdata_in  (lane16(ofs_c4)),
      .value_out (ofs_c4)
   );
   // Core 5 offset, independent of the pair
   ogt_trim_reg #(.W(`OGT_OFS_REG_W)) u_ofs_c5 (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .load_in   (fuse_load_q),
      .fuse_in   (fuse_ofs_c5_in),
      .wr_in     (wr_sel[4]),
      .wdata_in  (lane16(ofs_c5)),
      .value_out (ofs_c5)
   );

   // Gain registers (8 bit)
   // Core 0 fine gain
   ogt_trim_reg #(.W(`OGT_GAIN_REG_W)) u_gain_c0 (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .load_in   (fuse_load_q),
      .fuse_in   (fuse_gain_c0_in),
      .wr_in     (wr_sel[5]),
      .wdata_in  (lane8(gain_c0)),
      .value_out (gain_c0)
   );
   // Core 1 fine gain
   ogt_trim_reg #(.W(`OGT_GAIN_REG_W)) u_gain_c1 (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .load_in   (fuse_load_q),
      .fuse_in   (fuse_gain_c1_in),
      .wr_in     (wr_sel[6]),
      .wdata_in  (lane8(gain_c1)),
      .value_out (gain_c1)
   );
   // Core 2 fine gain, used while it samples the first pair
   ogt_trim_reg #(.W(`OGT_GAIN_REG_W)) u_gain_c2a (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .load_in   (fuse_load_q),
      .fuse_in   (fuse_gain_c2a_in),
      .wr_in     (wr_sel[7]),
      .wdata_in  (lane8(gain_c2a)),
      .value_out (gain_c2a)
   );

   // Keep bytes whose lane is disabled
   // so a narrow write to one byte leaves its neighbour alone; the gains
   // have only lane 0 behind them
   function [15:0] lane16;
      input [15:0] old;
      begin
         lane16 = {avs_byteenable_in[1] ? wd16[15:8] : old[15:8],
                   avs_byteenable_in[0] ? wd16[7:0]  : old[7:0]};
      end
   endfunction

   function [7:0] lane8;
      input [7:0] old;
      begin
         lane8 = avs_byteenable_in[0] ? wd8 : old;
      end
   endfunction

   // Read mux: full contents, zero above the register width
   // Reserved bits read back as stored; holes return zero so software
   // can probe the map without side effects
   always @* begin
      // hit is one-hot or zero, so plain items cover every case
      case (hit)
         8'h01:   rmux = {16'h0000, ofs_c2b};
         8'h02:   rmux = {16'h0000, ofs_c3c};
         8'h04:   rmux = {16'h0000, ofs_c3d};
         8'h08:   rmux = {16'h0000, ofs_c4};
         8'h10:   rmux = {16'h0000, ofs_c5};
         8'h20:   rmux = {24'h000000, gain_c0};
         8'h40:   rmux = {24'h000000, gain_c1};
         8'h80:   rmux = {24'h000000, gain_c2a};
         default: rmux = `OGT_UNMAPPED_DATA;     // Unmapped reads zero
      endcase
   end

   // Bus FSM: one wait cycle, one answer cycle, one release cycle.
   // The release cycle stops a held request being answered twice.
   // The cost is one dead cycle between back-to-back requests, which
   // is harmless for a bank that software touches only at setup.
   always @* begin
      case (st_q)
         ST_IDLE: st_d = (avs_read_in || avs_write_in) ? ST_ANS : ST_IDLE;
         ST_ANS:  st_d = ST_DONE;
         ST_DONE: st_d = ST_IDLE;
         default: st_d = ST_IDLE;
      endcase
   end

   // Registered bus outputs; waitrequest low only in the answer state
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_q                <= ST_IDLE;
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out    <= 32'h0000_0000;
      end else begin
         st_q                <= st_d;
         // Low for exactly the cycle in which the answer stands
         avs_waitrequest_out <= ~(st_d == ST_ANS);
         // Read data loads as the answer starts and stands afterwards
         if (st_d == ST_ANS && avs_read_in) begin
            avs_readdata_out <= rmux;
         end
      end
   end

   // Corrections toward the cores; offsets used as unsigned magnitudes.
   // Access during offset calibration is the software's to avoid.
   // Every output is registered, so it lags its register and selector by
   // one clock; a valid flag tells the core whether the word applies to
   // the pair it samples right now.
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         core2_ofs_out      <= 12'h000;
         core2_ofs_vld_out  <= 1'b0;
         core3_ofs_out      <= 12'h000;
         core3_ofs_vld_out  <= 1'b0;
         core4_ofs_out      <= 12'h000;
         core5_ofs_out      <= 12'h000;
         core0_gain_out     <= 5'h00;
         core1_gain_out     <= 5'h00;
         core2_gain_out     <= 5'h00;
         core2_gain_vld_out <= 1'b0;
         fuse_done_out      <= 1'b0;
      end else begin
         core2_ofs_out     <= ofs_c2b[`OGT_OFS_W-1:0];
         core2_ofs_vld_out <= (core2_sel_in == `OGT_SEL_B);
         // Core 3 picks its word by the pair it samples
         if (core3_sel_in == `OGT_SEL_D) begin
            core3_ofs_out <= ofs_c3d[`OGT_OFS_W-1:0];
         end else begin
            core3_ofs_out <= ofs_c3c[`OGT_OFS_W-1:0];
         end
         core3_ofs_vld_out <= (core3_sel_in == `OGT_SEL_C) ||
                              (core3_sel_in == `OGT_SEL_D);
         // Cores 4 and 5 do not depend on the pair
         core4_ofs_out      <= ofs_c4[`OGT_OFS_W-1:0];
         core5_ofs_out      <= ofs_c5[`OGT_OFS_W-1:0];
         // Fine gains, low five bits of each word
         core0_gain_out     <= gain_c0[`OGT_GAIN_W-1:0];
         core1_gain_out     <= gain_c1[`OGT_GAIN_W-1:0];
         core2_gain_out     <= gain_c2a[`OGT_GAIN_W-1:0];
         core2_gain_vld_out <= (core2_sel_in == `OGT_SEL_A);
         // Rises the clock the registers take the fuse words
         fuse_done_out      <= fuse_done_q;
      end
   end

endmodule

//--- rtl/ogt_map.vh
// Register map and field layout of the offset and gain trim bank.
// Assumes a byte-addressed Avalon-MM slave, one register per 32-bit word.
`ifndef OGT_MAP_VH
`define OGT_MAP_VH

// Printed register indices (not all multiples of four)
`define OGT_IDX_OFS_C2B    12'h336
`define OGT_IDX_OFS_C3C    12'h338
`define OGT_IDX_OFS_C3D    12'h33A
`define OGT_IDX_OFS_C4     12'h33C
`define OGT_IDX_OFS_C5     12'h33E
`define OGT_IDX_GAIN_C0    12'h360
`define OGT_IDX_GAIN_C1    12'h361
`define OGT_IDX_GAIN_C2A   12'h362

// Byte address is four times the index
`define OGT_ADDR_SHIFT     2

// Field widths
`define OGT_OFS_W          12
`define OGT_GAIN_W         5
`define OGT_OFS_REG_W      16
`define OGT_GAIN_REG_W     8

// Reset value of every trim register
`define OGT_RST_OFS        16'h0000
`define OGT_RST_GAIN       8'h00

// Fuse load sequencing: cycles after reset release before fuses are valid
`define OGT_FUSE_WAIT      4'h3

// Input pair selector codes
`define OGT_SEL_A          2'h0
`define OGT_SEL_B          2'h1
`define OGT_SEL_C          2'h2
`define OGT_SEL_D          2'h3

// Answer to an unmapped read
`define OGT_UNMAPPED_DATA  32'h0000_0000

`endif

//--- rtl/ogt_trim_reg.v
// One trim register: fuse default load, software write, readback.
// Assumes single clock, async active-low reset, fuse load pulse from top.
`timescale 1ns/1ns
module ogt_trim_reg #(
   parameter W = 16
) (
   input  wire         clk_in,      // System clock
   input  wire         nrst_in,     // Async reset, active low
   input  wire         load_in,     // One-cycle fuse load pulse
   input  wire [W-1:0] fuse_in,     // Factory trim from fuse storage
   input  wire         wr_in,       // Software write strobe
   input  wire [W-1:0] wdata_in,    // Software write data
   output wire [W-1:0] value_out    // Current register content
);

   reg [W-1:0] value_q;             // Held trim word

   // Reset to zero, fuse load at start, then software writes win
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         value_q <= {W{1'b0}};
      end else if (wr_in) begin
         value_q <= wdata_in;
      end else if (load_in) begin
         value_q <= fuse_in;
      end
   end

   assign value_out = value_q;
endmodule

//--- sim/ogt_trim_bank_checker.sv
// Checker of the trim bank: bus answer timing, pair flags, fuse load.
// Assumes a bind onto the top module; it sees only that module's ports.
`timescale 1ns/1ns
module ogt_trim_bank_checker (
   input wire        clk_in,
   input wire        nrst_in,
   input wire [13:0] avs_address_in,
   input wire        avs_read_in,
   input wire        avs_write_in,
   input wire [31:0] avs_writedata_in,
   input wire [3:0]  avs_byteenable_in,
   input wire        avs_waitrequest_out,
   input wire [15:0] fuse_ofs_c5_in,
   input wire [7:0]  fuse_gain_c0_in,
   input wire [1:0]  core2_sel_in,
   input wire [1:0]  core3_sel_in,
   input wire        core2_ofs_vld_out,
   input wire        core3_ofs_vld_out,
   input wire [11:0] core4_ofs_out,
   input wire [11:0] core5_ofs_out,
   input wire [4:0]  core0_gain_out,
   input wire [4:0]  core1_gain_out,
   input wire        core2_gain_vld_out,
   input wire        fuse_done_out
);
   // Write taken at this edge
   wire wr_acc = avs_write_in && !avs_waitrequest_out;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   // Flags follow the selector one clock late; skip the edge after reset
   a_core2_ofs_flag: assert property ($past(nrst_in) |->
      core2_ofs_vld_out == ($past(core2_sel_in) == 2'h1))
      else $error("core 2 offset flag wrong");
   a_core3_pair_flag: assert property ($past(nrst_in) |->
      core3_ofs_vld_out == ($past(core3_sel_in) >= 2'h2))
      else $error("core 3 offset flag wrong");
   a_core2_gain_flag: assert property ($past(nrst_in) |->
      core2_gain_vld_out == ($past(core2_sel_in) == 2'h0))
      else $error("core 2 gain flag wrong");
   // A write to the core 1 gain shows two edges later
   a_gain_write: assert property (wr_acc && avs_byteenable_in[0] &&
      avs_address_in == 14'hD84 |-> ##2
      core1_gain_out == $past(avs_writedata_in[4:0], 2))
      else $error("core 1 gain not taken from write");
   // Without a write the core 4 offset must not drift; a write or the
   // fuse load reaches the output two edges after it lands
   a_ofs_steady: assert property ($past(fuse_done_out, 2) &&
      !$past(wr_acc) && !$past(wr_acc, 2) |-> $stable(core4_ofs_out))
      else $error("core 4 offset changed without write");
   a_answer_bound: assert property ((avs_read_in || avs_write_in) &&
      avs_waitrequest_out |-> ##[1:2] !avs_waitrequest_out)
      else $error("bus request not answered in time");
   a_wait_pulse: assert property (!avs_waitrequest_out |=>
      avs_waitrequest_out)
      else $error("waitrequest low longer than one cycle");
   // Outputs show the fuse words one edge after the done flag rises
   a_fuse_defaults: assert property ($rose(fuse_done_out) |=>
      core5_ofs_out == fuse_ofs_c5_in[11:0] &&
      core0_gain_out == fuse_gain_c0_in[4:0])
      else $error("fuse defaults not in effect");
   a_fuse_done_hold: assert property (fuse_done_out |=> fuse_done_out)
      else $error("fuse done dropped");
endmodule

//--- sim/test_ogt_trim_bank.sv
// Self-checking bench of the trim bank, random traffic with fixed seed.
// Assumes the design files and the checker are compiled before this.
`timescale 1ns/1ns
module test_ogt_trim_bank;
   logic        clk_in, nrst_in, avs_read_in, avs_write_in;
   logic [13:0] avs_address_in;
   logic [31:0] avs_writedata_in;
   logic [3:0]  avs_byteenable_in;
   logic [1:0]  core2_sel_in, core3_sel_in;
   logic [15:0] fz [8];     // Factory trims, upper bits kept zero
   logic [15:0] mdl [8];    // Expected register contents
   int          seed = 97;
   int          err_total = 0;
   int          comparisons = 0;
   // Byte addresses, four times the register index
   logic [13:0] adr [8] = '{14'hCD8, 14'hCE0, 14'hCE8, 14'hCF0,
                            14'hCF8, 14'hD80, 14'hD84, 14'hD88};
   wire [15:0]  fuse_ofs_c2b_in = fz[0];
   wire [15:0]  fuse_ofs_c3c_in = fz[1];
   wire [15:0]  fuse_ofs_c3d_in = fz[2];
   wire [15:0]  fuse_ofs_c4_in = fz[3];
   wire [15:0]  fuse_ofs_c5_in = fz[4];
   wire [7:0]   fuse_gain_c0_in = fz[5][7:0];
   wire [7:0]   fuse_gain_c1_in = fz[6][7:0];
   wire [7:0]   fuse_gain_c2a_in = fz[7][7:0];
   wire [31:0]  avs_readdata_out;
   wire         avs_waitrequest_out, fuse_done_out;
   wire         core2_ofs_vld_out, core3_ofs_vld_out, core2_gain_vld_out;
   wire [11:0]  core2_ofs_out, core3_ofs_out, core4_ofs_out, core5_ofs_out;
   wire [4:0]   core0_gain_out, core1_gain_out, core2_gain_out;

   ogt_trim_bank i_ogt_trim_bank (.*);

   // 250 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   // Field bits software may set; reserved bits stay zero
   function automatic [15:0] fmask(input int i);
      fmask = (i < 5) ? 16'h0FFF : 16'h001F;
   endfunction

   // New content after a write with byte lanes; gains have one lane
   function automatic [15:0] merge(input int i, input [15:0] o,
                                   input [31:0] d, input [3:0] be);
      merge = o;
      if (be[0]) merge[7:0] = d[7:0];
      if (be[1] && i < 5) merge[15:8] = d[15:8];
   endfunction

   // Expected corrections for the two selector values
   function automatic [65:0] eo(input [1:0] s2, input [1:0] s3);
      logic [15:0] c3;
      c3 = (s3 == 2'h3) ? mdl[2] : mdl[1];
      eo = {mdl[0][11:0], s2 == 2'h1, c3[11:0], s3[1], mdl[3][11:0],
            mdl[4][11:0], mdl[5][4:0], mdl[6][4:0], mdl[7][4:0], s2 == 2'h0};
   endfunction

   task automatic chk(input logic [65:0] g, input logic [65:0] e);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic wrap_up;
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // One bus cycle; entered just after an edge, leaves one idle edge
   task automatic bus(input logic w, input logic [13:0] a,
                      input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
      int n;
      n = 0;
      avs_write_in <= w;
      avs_read_in <= !w;
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_byteenable_in <= be;
      do begin
         @(posedge clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 40);
      if (n >= 40) begin
         err_total++;
         wrap_up;
      end
      q = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      @(posedge clk_in);
   endtask

   task automatic wr(input int i, input [31:0] d, input [3:0] be);
      logic [31:0] q;
      bus(1'b1, adr[i], d, be, q);
      mdl[i] = merge(i, mdl[i], d, be);
   endtask

   task automatic rdc(input [13:0] a, input [15:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 4'hF, q);
      chk(q, e);
   endtask

   // Wait for the fuse defaults, bounded
   task automatic start;
      int n;
      n = 0;
      while (fuse_done_out !== 1'b1 && n < 20) begin
         @(posedge clk_in);
         n++;
      end
      if (n >= 20) begin
         err_total++;
         wrap_up;
      end
      @(posedge clk_in);
   endtask

   // All pair codes on both selectors, core 3 in reverse order
   task automatic sweep;
      for (int s = 0; s < 4; s++) begin
         core2_sel_in <= 2'(s);
         core3_sel_in <= 2'(3 - s);
         repeat (3) @(posedge clk_in);
         chk({core2_ofs_out, core2_ofs_vld_out, core3_ofs_out,
              core3_ofs_vld_out, core4_ofs_out, core5_ofs_out,
              core0_gain_out, core1_gain_out, core2_gain_out,
              core2_gain_vld_out}, eo(2'(s), 2'(3 - s)));
      end
   endtask

   task automatic rd_all;
      for (int i = 0; i < 8; i++) rdc(adr[i], mdl[i]);
   endtask

   // Watchdog cuts a hang short
   initial begin
      #100000;
      err_total++;
      wrap_up;
   end

   initial begin
      int k;
      logic [31:0] d;
      nrst_in = 1'b0;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_address_in = 14'h0;
      avs_writedata_in = 32'h0;
      avs_byteenable_in = 4'h0;
      core2_sel_in = 2'h0;
      core3_sel_in = 2'h0;
      for (int i = 0; i < 8; i++) fz[i] = 16'($random(seed)) & fmask(i);
      mdl = fz;
      repeat (6) @(posedge clk_in);
      nrst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      chk({core4_ofs_out, core0_gain_out}, 66'h0);
      start;
      sweep;
      rd_all;
      // Largest unsigned offset and a lone low lane
      wr(3, 32'h0000_0FFF, 4'hF);
      wr(0, 32'h0000_0ABC, 4'h1);
      wr(6, 32'h0000_0015, 4'h1);
      for (int i = 0; i < 24; i++) begin
         k = $unsigned($random(seed)) % 8;
         d = $random(seed) & fmask(k);
         wr(k, d, 4'($random(seed)));
         rdc(adr[k], mdl[k]);
      end
      sweep;
      // An unmapped place takes no write; it and an unaligned place read zero
      bus(1'b1, 14'hD8C, 32'h0000_FFFF, 4'hF, d);
      rdc(14'hD8C, 16'h0);
      rdc(adr[0] + 14'h2, 16'h0);
      rd_all;
      // Second reset in mid-run reloads the factory trims
      nrst_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      chk({fuse_done_out, core5_ofs_out, core1_gain_out}, 66'h0);
      nrst_in <= 1'b1;
      mdl = fz;
      start;
      sweep;
      rd_all;
      wrap_up;
   end
endmodule

bind ogt_trim_bank ogt_trim_bank_checker i_ogt_trim_bank_checker (.*);
